//--- logic/tbu_top.sv
// timebase counter with prescaler, overflow flag and ahb-lite registers
`timescale 1ns/100ps

module tbu_top #(
  parameter int DIV_W = 8
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // power mode
  input wire logic halt_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic hready_i,
  input wire logic [31:0] hwdata_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // interrupt
  output logic irq_o
);

  localparam int DW = tbu_pkg::DATA_W;
  localparam int BW = tbu_pkg::BUS_W;
  localparam int PW = tbu_pkg::SEL_W;

  // byte address of a register index
  function automatic logic [BW-1:0] reg_addr(input logic [7:0] idx);
    reg_addr = {{(BW-8){1'b0}}, idx} << tbu_pkg::IDX_SHIFT;
  endfunction : reg_addr

  // true when a latched address names the given register
  function automatic logic hits(input logic [BW-1:0] addr, input logic [7:0] idx);
    hits = (addr == reg_addr(idx));
  endfunction : hits

  // software state
  logic [DW-1:0] count_reg;
  logic count_enable_reg;
  logic overflow_irq_enable_reg;
  logic [PW-1:0] prescaler_select_reg;
  logic overflow_flag_reg;
  logic irq_status_reg;
  logic irq_mask_reg;

  // bus state
  tbu_pkg::tbu_bus_e bus_state_reg;
  logic [BW-1:0] addr_reg;
  logic write_reg;
  logic word_reg;
  logic [BW-1:0] hrdata_reg;

  // decoded strokes
  logic accept;
  logic data_cycle;
  logic wr_ok;
  logic rd_ok;
  logic wr_count;
  logic wr_csr;
  logic wr_stat;
  logic wr_mask;
  logic rd_csr;
  logic tick;
  logic wrap;
  logic [DW-1:0] csr_view;
  logic [BW-1:0] rdata_next;
  logic sel_count;
  logic sel_csr;
  logic sel_stat;
  logic sel_mask;
  logic [DW-1:0] wdata_byte;
  logic flag_req;
  logic sticky_req;

  // ---------------------------------------------------------------------------
  // ahb-lite slave: one wait state, address captured in the address phase
  // ---------------------------------------------------------------------------

  // a transfer is taken when selected, ready and nonsequential
  assign accept = hsel_i & hready_i & (htrans_i == tbu_pkg::HTRANS_NONSEQ);

  // sequencing of address phase, wait cycle and completion cycle
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus_state_reg <= tbu_pkg::TBU_BUS_IDLE;
    end else begin
      case (bus_state_reg)
        tbu_pkg::TBU_BUS_IDLE: begin
          if (accept) begin
            bus_state_reg <= tbu_pkg::TBU_BUS_WAIT;
          end
        end
        tbu_pkg::TBU_BUS_WAIT: begin
          bus_state_reg <= tbu_pkg::TBU_BUS_DONE;
        end
        tbu_pkg::TBU_BUS_DONE: begin
          if (accept) begin
            bus_state_reg <= tbu_pkg::TBU_BUS_WAIT;
          end else begin
            bus_state_reg <= tbu_pkg::TBU_BUS_IDLE;
          end
        end
        default: begin
          bus_state_reg <= tbu_pkg::TBU_BUS_IDLE;
        end
      endcase
    end
  end

  // address phase capture
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      addr_reg <= '0;
      write_reg <= 1'b0;
      word_reg <= 1'b0;
    end else if (accept && bus_state_reg != tbu_pkg::TBU_BUS_WAIT) begin
      addr_reg <= haddr_i;
      write_reg <= hwrite_i;
      word_reg <= (hsize_i == tbu_pkg::HSIZE_WORD);
    end
  end

  // the wait cycle is where the access actually acts on the registers
  assign data_cycle = (bus_state_reg == tbu_pkg::TBU_BUS_WAIT);
  assign wr_ok = data_cycle & write_reg & word_reg;
  assign rd_ok = data_cycle & ~write_reg;

  // register selects from the latched address
  assign sel_count = hits(addr_reg, tbu_pkg::IDX_COUNT);
  assign sel_csr = hits(addr_reg, tbu_pkg::IDX_CSR);
  assign sel_stat = hits(addr_reg, tbu_pkg::IDX_IRQ_STATUS);
  assign sel_mask = hits(addr_reg, tbu_pkg::IDX_IRQ_MASK);

  // write strobes per register
  assign wr_count = wr_ok & sel_count;
  assign wr_csr = wr_ok & sel_csr;
  assign wr_stat = wr_ok & sel_stat;
  assign wr_mask = wr_ok & sel_mask;

  // only the low byte of the write data reaches the registers
  assign wdata_byte = hwdata_i[DW-1:0];

  // a read of the control/status register clears the overflow flag
  assign rd_csr = rd_ok & sel_csr;

  // control/status image, reserved top bits forced low
  always_comb begin
    csr_view = '0;
    csr_view[tbu_pkg::CSR_FLAG_BIT] = overflow_flag_reg;
    csr_view[tbu_pkg::CSR_IRQ_EN_BIT] = overflow_irq_enable_reg;
    csr_view[tbu_pkg::CSR_EN_BIT] = count_enable_reg;
    csr_view[tbu_pkg::CSR_SEL_LSB +: PW] = prescaler_select_reg;
  end

  // read multiplexer, unmapped addresses read zero
  always_comb begin
    rdata_next = '0;
    if (sel_count) begin
      rdata_next[DW-1:0] = count_reg;
    end else if (sel_csr) begin
      rdata_next[DW-1:0] = csr_view;
    end else if (sel_stat) begin
      rdata_next[tbu_pkg::IRQ_WRAP_BIT] = irq_status_reg;
    end else if (sel_mask) begin
      rdata_next[tbu_pkg::IRQ_WRAP_BIT] = irq_mask_reg;
    end
  end

  // read data registered in the wait cycle, held until the next read
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hrdata_reg <= tbu_pkg::RDATA_RST;
    end else if (rd_ok) begin
      hrdata_reg <= rdata_next;
    end
  end

  // bus answers
  assign hrdata_o = hrdata_reg;
  assign hreadyout_o = (bus_state_reg != tbu_pkg::TBU_BUS_WAIT);
  assign hresp_o = tbu_pkg::HRESP_OKAY;

  // ---------------------------------------------------------------------------
  // control bits
  // ---------------------------------------------------------------------------

  // count enable; overflow and reserved bits ignore writes
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_enable_reg <= 1'b0;
    end else if (wr_csr) begin
      count_enable_reg <= wdata_byte[tbu_pkg::CSR_EN_BIT];
    end
  end

  // overflow interrupt enable
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      overflow_irq_enable_reg <= 1'b0;
    end else if (wr_csr) begin
      overflow_irq_enable_reg <= wdata_byte[tbu_pkg::CSR_IRQ_EN_BIT];
    end
  end

  // prescaler select field
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prescaler_select_reg <= tbu_pkg::SEL_RST;
    end else if (wr_csr) begin
      prescaler_select_reg <= wdata_byte[tbu_pkg::CSR_SEL_LSB +: PW];
    end
  end

  // ---------------------------------------------------------------------------
  // prescaler and counter
  // ---------------------------------------------------------------------------

  // divider runs only while enabled and the oscillator is not halted
  tbu_prescaler #(
    .SEL_W(PW),
    .DIV_W(DIV_W)
  ) u_prescaler (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .run_i(count_enable_reg),
    .freeze_i(halt_i),
    .select_i(prescaler_select_reg),
    .tick_o(tick)
  );

  // a tick at the top value is a wrap
  assign wrap = tick & (count_reg == tbu_pkg::COUNT_MAX);

  // counter: software load wins over the increment of the same cycle
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_reg <= tbu_pkg::COUNT_RST;
    end else if (wr_count) begin
      count_reg <= wdata_byte;
    end else if (tick) begin
      count_reg <= count_reg + {{(DW-1){1'b0}}, 1'b1};
    end
  end

  // ---------------------------------------------------------------------------
  // overflow flag and interrupt
  // ---------------------------------------------------------------------------

  // flag set by wrap only; read clears; a wrap on the clearing read wins
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      overflow_flag_reg <= 1'b0;
    end else if (wrap) begin
      overflow_flag_reg <= 1'b1;
    end else if (rd_csr) begin
      overflow_flag_reg <= 1'b0;
    end
  end

  // sticky event bit, cleared by writing one, set wins over clear
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_status_reg <= 1'b0;
    end else if (wrap) begin
      irq_status_reg <= 1'b1;
    end else if (wr_stat && wdata_byte[tbu_pkg::IRQ_WRAP_BIT]) begin
      irq_status_reg <= 1'b0;
    end
  end

  // mask register for the sticky event
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_mask_reg <= 1'b0;
    end else if (wr_mask) begin
      irq_mask_reg <= wdata_byte[tbu_pkg::IRQ_WRAP_BIT];
    end
  end

  // request sources: the flag itself and the unmasked sticky event
  assign flag_req = overflow_flag_reg;
  assign sticky_req = irq_status_reg & irq_mask_reg;

  // level request, always gated by the overflow irq enable
  assign irq_o = overflow_irq_enable_reg & (flag_req | sticky_req);

endmodule : tbu_top

//--- logic/tbu_pkg.sv
// shared constants for the timebase counter block
package tbu_pkg;

  // register indexes; byte address is four times the index
  localparam logic [7:0] IDX_COUNT = 8'h36;
  localparam logic [7:0] IDX_CSR = 8'h37;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h38;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h39;
  localparam int IDX_SHIFT = 2;

  // control/status field positions
  localparam int CSR_FLAG_BIT = 5;
  localparam int CSR_IRQ_EN_BIT = 4;
  localparam int CSR_EN_BIT = 3;
  localparam int CSR_SEL_LSB = 0;
  localparam int SEL_W = 3;

  // interrupt status / mask field positions
  localparam int IRQ_WRAP_BIT = 0;

  // widths and reset values
  localparam int DATA_W = 8;
  localparam int BUS_W = 32;
  localparam logic [DATA_W-1:0] COUNT_RST = 8'h00;
  localparam logic [DATA_W-1:0] COUNT_MAX = 8'hff;
  localparam logic [SEL_W-1:0] SEL_RST = 3'h0;
  localparam logic [BUS_W-1:0] RDATA_RST = 32'h0000_0000;

  // ahb-lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'h0;

  // bus slave sequencing
  typedef enum logic [1:0] {
    TBU_BUS_IDLE,
    TBU_BUS_WAIT,
    TBU_BUS_DONE
  } tbu_bus_e;

endpackage : tbu_pkg

//--- logic/tbu_prescaler.sv
// power-of-two prescaler producing one tick per division period
`timescale 1ns/100ps

module tbu_prescaler #(
  parameter int SEL_W = 3,
  parameter int DIV_W = 8
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // control
  input wire logic run_i,
  input wire logic freeze_i,
  input wire logic [SEL_W-1:0] select_i,
  // tick out
  output logic tick_o
);

  logic [DIV_W-1:0] div_reg;
  logic [DIV_W-1:0] period_mask;

  // low (select+1) bits set: divide by 2 at code 0 up to 256 at code 7
  always_comb begin
    period_mask = '0;
    for (int i = 0; i < DIV_W; i++) begin
      if (i <= int'(select_i)) begin
        period_mask[i] = 1'b1;
      end
    end
  end

  // divider held in reset while stopped, frozen while halted
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_reg <= '0;
    end else if (!run_i) begin
      div_reg <= '0;
    end else if (!freeze_i) begin
      div_reg <= div_reg + {{(DIV_W-1){1'b0}}, 1'b1};
    end
  end

  // tick on the last cycle of each period
  assign tick_o = run_i & ~freeze_i & (&(div_reg | ~period_mask));

endmodule : tbu_prescaler

//--- bench/tbu_top_sva.sv
// assertion checker for the timebase counter ports
`timescale 1ns/100ps

module tbu_checker (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // bus and interrupt
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic irq_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // decoded read address phases
  wire logic take = hsel_i && hready_i && (htrans_i == tbu_pkg::HTRANS_NONSEQ);
  wire logic rd_csr = take && !hwrite_i && (haddr_i == {22'h0, tbu_pkg::IDX_CSR, 2'h0});
  wire logic rd_cnt = take && !hwrite_i && (haddr_i == {22'h0, tbu_pkg::IDX_COUNT, 2'h0});

  reset_zero_a: assert property (
    $rose(rst_n_i) |-> !irq_o && hrdata_o == 32'h0 && hreadyout_o)
    else $error("outputs not idle after reset");
  wait_state_a: assert property (
    take |=> !hreadyout_o ##1 hreadyout_o)
    else $error("wait state not exactly one cycle");
  resp_okay_a: assert property (
    hresp_o == tbu_pkg::HRESP_OKAY)
    else $error("response not okay");
  csr_reserved_a: assert property (
    rd_csr |-> ##2 hrdata_o[31:6] == 26'h0)
    else $error("reserved control bits read nonzero");
  count_width_a: assert property (
    rd_cnt |-> ##2 hrdata_o[31:8] == 24'h0)
    else $error("count read wider than eight bits");
  flag_clear_a: assert property (
    rd_csr ##2 (hrdata_o[5] && !hrdata_o[3]) ##1 rd_csr |-> ##2 !hrdata_o[5])
    else $error("overflow flag survived a read");
  irq_gate_a: assert property (
    rd_csr ##2 !hrdata_o[4] |-> !irq_o)
    else $error("request with interrupt disabled");
  irq_fall_a: assert property (
    $fell(irq_o) |-> $rose(hreadyout_o))
    else $error("request dropped outside a transfer");
endmodule : tbu_checker

bind tbu_top tbu_checker chk_u (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
  .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
  .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .irq_o(irq_o));

//--- bench/tb_top.sv
// self-checking testbench for the timebase counter
`timescale 1ns/100ps

module tb_top;
  localparam logic [31:0] A_CNT = {22'h0, tbu_pkg::IDX_COUNT, 2'h0};
  localparam logic [31:0] A_CSR = {22'h0, tbu_pkg::IDX_CSR, 2'h0};
  localparam logic [31:0] A_STS = {22'h0, tbu_pkg::IDX_IRQ_STATUS, 2'h0};
  localparam logic [31:0] A_MSK = {22'h0, tbu_pkg::IDX_IRQ_MASK, 2'h0};
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic halt_i = 1'b0;
  logic [31:0] haddr_i = 32'h0;
  logic [1:0] htrans_i = 2'h0;
  logic hwrite_i = 1'b0;
  logic [2:0] hsize_i = 3'h2;
  logic [31:0] hwdata_i = 32'h0;
  logic [31:0] hrdata_o;
  logic hreadyout_o;
  logic hresp_o;
  logic irq_o;
  logic [31:0] rd;
  int err_total = 0;
  int compares = 0;

  // system clock, 25 ns period
  always #12.5 clk_sys_i = ~clk_sys_i;

  tbu_top dut (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .halt_i(halt_i), .hsel_i(1'b1),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
    .hready_i(hreadyout_o), .hwdata_i(hwdata_i), .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .irq_o(irq_o));

  // one single transfer; each phase held until hready is seen high
  task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wd);
    logic rdy;
    htrans_i <= tbu_pkg::HTRANS_NONSEQ;
    haddr_i <= addr;
    hwrite_i <= wr;
    hsize_i <= tbu_pkg::HSIZE_WORD;
    for (int ph = 0; ph < 2; ph++) begin
      do begin
        @(negedge clk_sys_i);
        rdy = hreadyout_o;
        rd = hrdata_o;
        @(posedge clk_sys_i);
      end while (!rdy);
      if (ph == 0) begin
        htrans_i <= 2'h0;
        hwdata_i <= wd;
      end
    end
  endtask : xfer

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rchk(input logic [31:0] addr, input logic [31:0] exp);
    xfer(1'b0, addr, 32'h0);
    chk(rd, exp);
  endtask : rchk

  // interrupt level sampled between edges
  task automatic ichk(input logic exp);
    @(negedge clk_sys_i);
    chk({31'h0, irq_o}, {31'h0, exp});
    @(posedge clk_sys_i);
  endtask : ichk

  task automatic t_reset();
    rchk(A_CNT, 32'h0);
    rchk(A_CSR, 32'h0);
    rchk(32'h0000_0100, 32'h0);
    ichk(1'b0);
    $display("test reset done");
  endtask : t_reset

  // load count with bits above the low byte dropped; the flag bit ignores writes
  task automatic t_regs();
    xfer(1'b1, A_CNT, 32'h0000_01a5);
    rchk(A_CNT, 32'h0000_00a5);
    xfer(1'b1, A_CSR, 32'h0000_0027);
    rchk(A_CSR, 32'h0000_0007);
    $display("test regs done");
  endtask : t_regs

  // every divider code, resuming from the loaded count
  task automatic t_div();
    int n;
    for (int s = 0; s < 8; s++) begin
      n = 2 << s;
      xfer(1'b1, A_CNT, 32'h0000_00f0);
      xfer(1'b1, A_CSR, 32'h8 | 32'(s));
      repeat (3 * n - 2) @(posedge clk_sys_i);
      xfer(1'b1, A_CSR, 32'(s));
      rchk(A_CNT, 32'h0000_00f3);
      repeat (n) @(posedge clk_sys_i);
      rchk(A_CNT, 32'h0000_00f3);
    end
    $display("test divider done");
  endtask : t_div

  // halt freezes counting mid-run
  task automatic t_halt();
    xfer(1'b1, A_CNT, 32'h0000_0010);
    xfer(1'b1, A_CSR, 32'h0000_0008);
    repeat (5) @(posedge clk_sys_i);
    halt_i <= 1'b1;
    repeat (10) @(posedge clk_sys_i);
    halt_i <= 1'b0;
    repeat (5) @(posedge clk_sys_i);
    xfer(1'b1, A_CSR, 32'h0);
    rchk(A_CNT, 32'h0000_0016);
    $display("test halt done");
  endtask : t_halt

  // one wrap with interrupt enabled, then stop
  task automatic wrap();
    xfer(1'b1, A_CNT, 32'h0000_00fe);
    xfer(1'b1, A_CSR, 32'h0000_0018);
    repeat (8) @(posedge clk_sys_i);
    xfer(1'b1, A_CSR, 32'h0000_0010);
  endtask : wrap

  task automatic t_irq();
    wrap();
    ichk(1'b1);
    rchk(A_CSR, 32'h0000_0030);
    rchk(A_CSR, 32'h0000_0010);
    ichk(1'b0);
    rchk(A_STS, 32'h1);
    xfer(1'b1, A_MSK, 32'h1);
    ichk(1'b1);
    xfer(1'b1, A_STS, 32'h1);
    ichk(1'b0);
    rchk(A_STS, 32'h0);
    wrap();
    xfer(1'b1, A_CSR, 32'h0);
    ichk(1'b0);
    rchk(A_CSR, 32'h0000_0020);
    xfer(1'b1, A_STS, 32'h1);
    xfer(1'b1, A_MSK, 32'h0);
    $display("test interrupt done");
  endtask : t_irq

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report

  // main sequence
  initial begin
    repeat (12) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    t_reset();
    t_regs();
    t_div();
    t_halt();
    t_irq();
    final_report();
  end

  // watchdog
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    err_total++;
    final_report();
  end
endmodule : tb_top
